/* File: src/servo_profile_cfg.svh */
// object indices, bit positions, reset values and mode codes of the profile mode block
`ifndef SERVO_PROFILE_CFG_SVH
`define SERVO_PROFILE_CFG_SVH
`define IDX_CTRL_WORD 16'h6040
`define IDX_STATUS_WORD 16'h6041
`define IDX_MODE_SELECT 16'h6060
`define IDX_MODE_SHOW 16'h6061
`define IDX_TORQUE_TARGET 16'h6071
`define IDX_VELOCITY_CEILING 16'h607f
`define IDX_ACCEL_RAMP 16'h6083
`define IDX_DECEL_RAMP 16'h6084
`define IDX_REL_MOVE_REF 16'h60f2
`define IDX_VELOCITY_TARGET 16'h60ff
`define MODE_PROFILE_POS 8'h01
`define MODE_PROFILE_VEL 8'h03
`define MODE_PROFILE_TRQ 8'h04
`define REL_REF_PREV_TARGET 16'h0000
`define REL_REF_ACTUAL_POS 16'h0002
`define CW_QUICK_STOP 2
`define CW_RELATIVE 6
`define CW_FAULT_RESET 7
`define CW_HALT 8
`define SW_HALT_ACTIVE 8
`define SW_TARGET_REACHED 10
`define SW_MODE_SPECIFIC 12
`define SW_ERROR 13
`define SW_MODE_DONE 14
`define SW_ZERO_VALID 15
`define RST_CTRL_WORD 16'h0000
`define RST_MODE_SELECT 8'h00
`define RST_TORQUE_TARGET 16'h0000
`define RST_VELOCITY_CEILING 32'hffffffff
`define RST_ACCEL_RAMP 32'hfe502aab
`define RST_DECEL_RAMP 32'hfe502aab
`define RST_REL_MOVE_REF 16'h0000
`define RST_VELOCITY_TARGET 32'h00000000
`define RAMP_MIN 32'h00000001
`endif

/* File: src/servo_profile_pkg.sv */
// types shared by the profile mode block
package servo_profile_pkg;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0] mode;
		logic [15:0] torque;
		logic [31:0] ceiling;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [15:0] rel_ref;
		logic [31:0] vel;
		logic err;
		logic done;
		logic moving;
		logic fault_pulse;
		logic [31:0] rdata;
		logic rvalid;
		logic rerr;
		logic wack;
		logic werr;
	} ctl_state_t;
endpackage

/* File: src/servo_profile_mode_control.sv */
// mode selection, command objects and status word of the profile modes
// Contract
// - profile position ends only at standstill after target, halt, quick stop or error
// - velocity and torque modes end only at standstill after halt, quick stop or error
// - 16-bit relative reference option, 0 previous target, 2 actual position, default 0
// - writable 32-bit velocity ceiling, least value 1, bounds profile velocity
// - writing the mode selector starts that mode at once
// - velocity mode starts moving when the signed 32-bit target velocity is written
// - torque mode starts producing torque when the signed 16-bit target torque is written
// - one torque unit is one thousandth of nominal torque
// - separate 32-bit acceleration and deceleration ramps, least value 1
// - control bit 2 commands a quick stop in velocity and torque modes
// - control bit 7 commands a fault reset
// - control bit 8 halts; status bit 8 shows an active halt request
// - control bits 4 to 6 and 9 are ignored in velocity and torque modes
// - velocity mode status bit 10 is 1 when actual velocity equals target
// - torque mode status bit 10 is 1 when target torque is reached
// - velocity mode status bit 12 is 1 at zero velocity; no meaning in torque
// - status bit 13 is 1 while an error is detected; the code latches it on error_seen and holds it until a fault reset
// - status bit 14 is 0 after mode start and 1 once terminated
// - status bit 15 is 1 while a valid zero point exists
// - mode codes 1 position, 3 velocity, 4 torque, echoed by the mode display
// - in position mode control bit 6 selects absolute (0) or relative (1)
`include "servo_profile_cfg.svh"
module servo_profile_mode_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic obj_wr,
	input wire logic obj_rd,
	input wire logic [15:0] obj_index,
	input wire logic [31:0] obj_wdata,
	output logic [31:0] obj_rdata,
	output logic obj_rvalid,
	output logic obj_rerr,
	output logic obj_wack,
	output logic obj_werr,
	input wire logic standstill,
	input wire logic pos_reached,
	input wire logic error_seen,
	input wire logic zero_valid,
	input wire logic [31:0] actual_velocity,
	input wire logic [15:0] actual_torque,
	output logic [7:0] active_mode,
	output logic motion_enable,
	output logic [31:0] velocity_cmd,
	output logic [15:0] torque_cmd_permille,
	output logic [31:0] accel_cmd,
	output logic [31:0] decel_cmd,
	output logic quick_stop,
	output logic halt,
	output logic fault_reset,
	output logic relative_move,
	output logic rel_from_actual,
	output logic mode_done,
	output logic [15:0] status_word
);
	servo_profile_pkg::ctl_state_t st_r;
	servo_profile_pkg::ctl_state_t st_nxt;
	logic is_pp;
	logic is_pv;
	logic is_pt;
	logic stop_req;
	logic end_cond;
	logic [31:0] vel_mag;
	logic [31:0] mag_clip;
	logic [31:0] vel_clip;
	logic target_hit;
	logic [15:0] sw;

	// mode decode from the selector code
	assign is_pp = st_r.mode == `MODE_PROFILE_POS;
	assign is_pv = st_r.mode == `MODE_PROFILE_VEL;
	assign is_pt = st_r.mode == `MODE_PROFILE_TRQ;

	// clip target velocity magnitude to the ceiling, keep the sign
	assign vel_mag = st_r.vel[31] ? 32'(-st_r.vel) : st_r.vel;
	assign mag_clip = (vel_mag > st_r.ceiling) ? st_r.ceiling : vel_mag;
	assign vel_clip = st_r.vel[31] ? 32'(-mag_clip) : mag_clip;

	// stop sources that may end a mode once the motor stands still
	assign stop_req = st_r.ctrl[`CW_HALT] | st_r.ctrl[`CW_QUICK_STOP] | st_r.err;
	always_comb
	begin
		end_cond = 1'b0;
		if (is_pp)
			end_cond = standstill & (pos_reached | stop_req);
		else if (is_pv || is_pt)
			end_cond = standstill & stop_req;
	end

	// target reached per mode
	always_comb
	begin
		target_hit = 1'b0;
		if (is_pp)
			target_hit = pos_reached;
		else if (is_pv)
			target_hit = actual_velocity == vel_clip;
		else if (is_pt)
			target_hit = actual_torque == st_r.torque;
	end

	// status word assembly, other bits read as zero
	always_comb
	begin
		sw = 16'h0000;
		sw[`SW_HALT_ACTIVE] = st_r.ctrl[`CW_HALT];
		sw[`SW_TARGET_REACHED] = target_hit;
		sw[`SW_MODE_SPECIFIC] = is_pv & (actual_velocity == 32'h00000000);
		sw[`SW_ERROR] = st_r.err;
		sw[`SW_MODE_DONE] = st_r.done;
		sw[`SW_ZERO_VALID] = zero_valid;
	end

	// object writes, reads, error latch and mode tracking
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.fault_pulse = 1'b0;
		st_nxt.rvalid = 1'b0;
		st_nxt.rerr = 1'b0;
		st_nxt.wack = 1'b0;
		st_nxt.werr = 1'b0;
		// fault reset on a rising control bit 7 clears the error latch
		if (st_r.fault_pulse)
			st_nxt.err = 1'b0;
		// termination clears motion; the done flag is set here
		if (end_cond)
		begin
			st_nxt.done = 1'b1;
			st_nxt.moving = 1'b0;
		end
		if (obj_wr)
		begin
			st_nxt.wack = 1'b1;
			case (obj_index)
				`IDX_CTRL_WORD:
				begin
					st_nxt.ctrl = obj_wdata[15:0];
					st_nxt.fault_pulse = obj_wdata[`CW_FAULT_RESET]
						& ~st_r.ctrl[`CW_FAULT_RESET];
				end
				`IDX_MODE_SELECT:
				begin
					st_nxt.mode = obj_wdata[7:0];
					st_nxt.done = end_cond;
					st_nxt.moving = 1'b0;
				end
				`IDX_TORQUE_TARGET:
				begin
					st_nxt.torque = obj_wdata[15:0];
					if (is_pt && !end_cond)
						st_nxt.moving = 1'b1;
				end
				`IDX_VELOCITY_TARGET:
				begin
					st_nxt.vel = obj_wdata;
					if (is_pv && !end_cond)
						st_nxt.moving = 1'b1;
				end
				`IDX_VELOCITY_CEILING:
					if (obj_wdata >= `RAMP_MIN)
						st_nxt.ceiling = obj_wdata;
					else
						st_nxt.werr = 1'b1;
				`IDX_ACCEL_RAMP:
					if (obj_wdata >= `RAMP_MIN)
						st_nxt.accel = obj_wdata;
					else
						st_nxt.werr = 1'b1;
				`IDX_DECEL_RAMP:
					if (obj_wdata >= `RAMP_MIN)
						st_nxt.decel = obj_wdata;
					else
						st_nxt.werr = 1'b1;
				`IDX_REL_MOVE_REF:
					st_nxt.rel_ref = obj_wdata[15:0];
				default:
					st_nxt.werr = 1'b1;
			endcase
		end
		// error event wins over a fault reset in the same cycle
		if (error_seen)
			st_nxt.err = 1'b1;
		if (obj_rd)
		begin
			st_nxt.rvalid = 1'b1;
			case (obj_index)
				`IDX_CTRL_WORD: st_nxt.rdata = {16'h0000, st_r.ctrl};
				`IDX_STATUS_WORD: st_nxt.rdata = {16'h0000, sw};
				`IDX_MODE_SELECT: st_nxt.rdata = {24'h000000, st_r.mode};
				`IDX_MODE_SHOW: st_nxt.rdata = {24'h000000, st_r.mode};
				`IDX_TORQUE_TARGET: st_nxt.rdata = {16'h0000, st_r.torque};
				`IDX_VELOCITY_CEILING: st_nxt.rdata = st_r.ceiling;
				`IDX_ACCEL_RAMP: st_nxt.rdata = st_r.accel;
				`IDX_DECEL_RAMP: st_nxt.rdata = st_r.decel;
				`IDX_REL_MOVE_REF: st_nxt.rdata = {16'h0000, st_r.rel_ref};
				`IDX_VELOCITY_TARGET: st_nxt.rdata = st_r.vel;
				default:
				begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rerr = 1'b1;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.ctrl <= `RST_CTRL_WORD;
			st_r.mode <= `RST_MODE_SELECT;
			st_r.torque <= `RST_TORQUE_TARGET;
			st_r.ceiling <= `RST_VELOCITY_CEILING;
			st_r.accel <= `RST_ACCEL_RAMP;
			st_r.decel <= `RST_DECEL_RAMP;
			st_r.rel_ref <= `RST_REL_MOVE_REF;
			st_r.vel <= `RST_VELOCITY_TARGET;
		end
		else
			st_r <= st_nxt;
	end

	// drive outputs
	assign obj_rdata = st_r.rdata;
	assign obj_rvalid = st_r.rvalid;
	assign obj_rerr = st_r.rerr;
	assign obj_wack = st_r.wack;
	assign obj_werr = st_r.werr;
	assign active_mode = st_r.mode;
	assign motion_enable = st_r.moving;
	assign velocity_cmd = is_pv ? vel_clip : 32'h00000000;
	assign torque_cmd_permille = is_pt ? st_r.torque : 16'h0000;
	assign accel_cmd = st_r.accel;
	assign decel_cmd = st_r.decel;
	assign quick_stop = st_r.ctrl[`CW_QUICK_STOP];
	assign halt = st_r.ctrl[`CW_HALT];
	assign fault_reset = st_r.fault_pulse;
	assign relative_move = is_pp & st_r.ctrl[`CW_RELATIVE];
	assign rel_from_actual = st_r.rel_ref == `REL_REF_ACTUAL_POS;
	assign mode_done = st_r.done;
	assign status_word = sw;

	// checks of termination, mode entry and status
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_pp_end_cond: assert property (is_pp && !standstill && !obj_wr |=>
		st_r.done == $past(st_r.done)) else $error("position mode ended while moving");
	chk_pv_no_end: assert property ((is_pv || is_pt) && !stop_req && !obj_wr |=>
		st_r.done == $past(st_r.done)) else $error("mode ended without stop cause");
	chk_mode_write: assert property (obj_wr && obj_index == `IDX_MODE_SELECT |=>
		active_mode == 8'($past(obj_wdata))) else $error("mode write not taken");
	chk_vel_start: assert property (obj_wr && obj_index == `IDX_VELOCITY_TARGET
		&& is_pv && !end_cond |=> motion_enable) else $error("velocity write did not start");
	chk_trq_start: assert property (obj_wr && obj_index == `IDX_TORQUE_TARGET
		&& is_pt && !end_cond |=> motion_enable) else $error("torque write did not start");
	chk_ramp_min: assert property (accel_cmd >= `RAMP_MIN && decel_cmd >= `RAMP_MIN
		&& st_r.ceiling >= `RAMP_MIN) else $error("ramp or ceiling below one");
	chk_fault_clear: assert property (fault_reset && !error_seen |=>
		!status_word[`SW_ERROR]) else $error("fault reset did not clear error");
	chk_halt_bit: assert property (status_word[`SW_HALT_ACTIVE] == halt)
		else $error("halt status mismatch");
	chk_err_set: assert property (error_seen |=> status_word[`SW_ERROR])
		else $error("error not flagged");
	chk_done_set: assert property (end_cond |=> status_word[`SW_MODE_DONE])
		else $error("termination not flagged");
	chk_clip_bound: assert property (is_pv |-> st_r.ceiling >=
		(velocity_cmd[31] ? 32'(-velocity_cmd) : velocity_cmd))
		else $error("velocity not clipped");
	chk_rel_masked: assert property (!is_pp |-> !relative_move)
		else $error("relative flag outside position mode");

	// checks of object writes, stop handling and status bits
	chk_werr_ceiling: assert property (obj_wr && obj_index == `IDX_VELOCITY_CEILING
		&& obj_wdata < `RAMP_MIN |=> obj_werr && st_r.ceiling == $past(st_r.ceiling))
		else $error("ceiling of zero accepted");
	chk_accel_write: assert property (obj_wr && obj_index == `IDX_ACCEL_RAMP
		&& obj_wdata >= `RAMP_MIN |=> accel_cmd == $past(obj_wdata))
		else $error("acceleration write not taken");
	chk_decel_write: assert property (obj_wr && obj_index == `IDX_DECEL_RAMP
		&& obj_wdata >= `RAMP_MIN |=> decel_cmd == $past(obj_wdata))
		else $error("deceleration write not taken");
	chk_rel_ref: assert property (obj_wr && obj_index == `IDX_REL_MOVE_REF |=>
		rel_from_actual == (16'($past(obj_wdata)) == `REL_REF_ACTUAL_POS))
		else $error("relative reference option not applied");
	chk_done_clear: assert property (obj_wr && obj_index == `IDX_MODE_SELECT
		&& !end_cond |=> !mode_done) else $error("mode write left done flag set");
	chk_qs_end: assert property ((is_pv || is_pt) && standstill && quick_stop |=>
		mode_done) else $error("quick stop at standstill did not end mode");
	chk_halt_stop: assert property (is_pp && standstill && halt |=> mode_done)
		else $error("halt at standstill did not end position mode");
	chk_zero_flag: assert property (status_word[`SW_ZERO_VALID] == zero_valid)
		else $error("zero point flag mismatch");
	chk_trq_bit: assert property (is_pt && actual_torque == torque_cmd_permille |->
		status_word[`SW_TARGET_REACHED]) else $error("torque target not flagged");
	chk_vel_bit: assert property (is_pv && actual_velocity == velocity_cmd |->
		status_word[`SW_TARGET_REACHED]) else $error("velocity target not flagged");
	chk_fault_pulse: assert property (fault_reset |=> !fault_reset)
		else $error("fault reset longer than one cycle");
	chk_ignored_bits: assert property ((is_pv || is_pt) && obj_wr && !end_cond
		&& obj_index == `IDX_CTRL_WORD
		&& (obj_wdata[15:0] & ~16'h0270) == (st_r.ctrl & ~16'h0270)
		|=> motion_enable == $past(motion_enable)) else $error("ignored control bits acted");
endmodule // servo_profile_mode_control

/* File: bench/motor_plant.sv */
// behavioural motor stage answering the profile mode commands
module motor_plant (
	input wire logic clk,
	input wire logic motion_enable,
	input wire logic halt,
	input wire logic quick_stop,
	input wire logic [31:0] velocity_cmd,
	input wire logic [15:0] torque_cmd_permille,
	output logic standstill,
	output logic [31:0] actual_velocity,
	output logic [15:0] actual_torque
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run;
	assign run = motion_enable && !halt && !quick_stop;
	// speed and torque take the command at the next falling clock edge and drop to zero on a stop or without motion enable
	always @(negedge clk)
	begin
		actual_velocity <= run ? velocity_cmd : 32'h0;
		actual_torque <= run ? torque_cmd_permille : 16'h0;
	end
	assign standstill = (actual_velocity == 32'h0) && (actual_torque == 16'h0);
endmodule // motor_plant

/* File: bench/tb.sv */
// self-checking bench of the profile mode control block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	localparam logic [31:0] F = 32'hffffffff;
	note_t notes[$];
	note_t n;
	logic clk = 0, rst = 1, obj_wr = 0, obj_rd = 0;
	logic pos_reached = 0, error_seen = 0, zero_valid = 0;
	logic [15:0] obj_index = 16'h0;
	logic [31:0] obj_wdata = 32'h0;
	logic [31:0] obj_rdata, velocity_cmd, accel_cmd, decel_cmd, actual_velocity, v, x;
	logic [15:0] status_word, torque_cmd_permille, actual_torque;
	logic [15:0] lfsr = 16'h2;
	logic [7:0] active_mode;
	logic [7:0] modes[3] = '{8'h01, 8'h03, 8'h04};
	logic obj_rvalid, obj_rerr, obj_wack, obj_werr, standstill, motion_enable;
	logic quick_stop, halt, fault_reset, relative_move, rel_from_actual, mode_done;
	int errors = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	servo_profile_mode_control i_dut (.clk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_wdata,
		.obj_rdata, .obj_rvalid, .obj_rerr, .obj_wack, .obj_werr, .standstill, .pos_reached,
		.error_seen, .zero_valid, .actual_velocity, .actual_torque, .active_mode,
		.motion_enable, .velocity_cmd, .torque_cmd_permille, .accel_cmd, .decel_cmd,
		.quick_stop, .halt, .fault_reset, .relative_move, .rel_from_actual, .mode_done,
		.status_word);
	motor_plant i_plant (.clk, .motion_enable, .halt, .quick_stop, .velocity_cmd,
		.torque_cmd_permille, .standstill, .actual_velocity, .actual_torque);
	// compare one value and count it
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one object access; d is write data or expected read data
	task automatic acc(logic w, logic [15:0] i, logic [31:0] d, logic [31:0] m, logic e);
		@(negedge clk);
		obj_wr = w;
		obj_rd = !w;
		obj_index = i;
		obj_wdata = d;
		notes.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
		@(negedge clk);
		obj_wr = 0;
		obj_rd = 0;
	endtask
	task automatic idle(int c);
		repeat (c) @(negedge clk);
	endtask
	// next value of the stimulus shift register
	function automatic logic [15:0] lfsr_step(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// take the oldest note whenever an answer appears
	always @(posedge clk)
	begin
		#1;
		if (obj_wack === 1'b1 || obj_rvalid === 1'b1)
		begin
			if (notes.size() == 0)
				chk("spare answer", 32'h0, 32'h1);
			else
			begin
				n = notes.pop_front();
				chk("obj_rdata", n.d, obj_rdata & n.m);
				chk("refusal", {31'h0, n.e}, {31'h0, obj_wack ? obj_werr : obj_rerr});
			end
		end
	end
	// cut a hang short
	initial
	begin
		#50us;
		errors++;
		stop_test();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 0;
		acc(0, 16'h6071, 32'h0, F, 0);
		acc(0, 16'h607f, F, F, 0);
		acc(0, 16'h6083, 32'hfe502aab, F, 0);
		acc(0, 16'h6084, 32'hfe502aab, F, 0);
		acc(0, 16'h60f2, 32'h0, F, 0);
		acc(0, 16'h60ff, 32'h0, F, 0);
		acc(0, 16'h1234, 32'h0, F, 1);
		acc(1, 16'h6041, 32'h1, 32'h0, 1);
		acc(1, 16'h607f, 32'h0, 32'h0, 1);
		acc(1, 16'h6084, 32'h0, 32'h0, 1);
		chk("accel_cmd", 32'hfe502aab, accel_cmd);
		chk("decel_cmd", 32'hfe502aab, decel_cmd);
		acc(1, 16'h6083, 32'h1, 32'h0, 0);
		acc(1, 16'h6084, 32'h2, 32'h0, 0);
		chk("accel_cmd", 32'h1, accel_cmd);
		chk("decel_cmd", 32'h2, decel_cmd);
		foreach (modes[k])
		begin
			acc(1, 16'h6060, {24'h0, modes[k]}, 32'h0, 0);
			acc(0, 16'h6061, {24'h0, modes[k]}, 32'hff, 0);
			chk("active_mode", {24'h0, modes[k]}, {24'h0, active_mode});
		end
		// velocity mode with random targets, clipped to the ceiling
		acc(1, 16'h6060, 32'h3, 32'h0, 0);
		acc(1, 16'h607f, 32'd1000, 32'h0, 0);
		repeat (4)
		begin
			repeat (5) lfsr = lfsr_step(lfsr);
			v = {{16{lfsr[15]}}, lfsr};
			x = ($signed(v) > 1000) ? 32'd1000 : ($signed(v) < -1000) ? -32'd1000 : v;
			acc(1, 16'h60ff, v, 32'h0, 0);
			idle(2);
			chk("velocity_cmd", x, velocity_cmd);
			chk("motion_enable", 32'h1, {31'h0, motion_enable});
			acc(0, 16'h6041, {19'h0, x == 0, 12'h400}, 32'h1400, 0);
		end
		acc(1, 16'h60ff, -32'd5000, 32'h0, 0);
		idle(2);
		chk("velocity_cmd", -32'd1000, velocity_cmd);
		acc(1, 16'h6040, 32'h100, 32'h0, 0);
		idle(3);
		chk("halt", 32'h1, {31'h0, halt});
		chk("motion_enable", 32'h0, {31'h0, motion_enable});
		acc(0, 16'h6041, 32'h5100, 32'h5500, 0);
		chk("mode_done", 32'h1, {31'h0, mode_done});
		acc(1, 16'h6040, 32'h0, 32'h0, 0);
		acc(1, 16'h6060, 32'h4, 32'h0, 0);
		acc(0, 16'h6041, 32'h0, 32'h4000, 0);
		// torque mode, then ignored bits and quick stop
		acc(1, 16'h6071, 32'd250, 32'h0, 0);
		idle(2);
		chk("torque_cmd", 32'd250, {16'h0, torque_cmd_permille});
		acc(0, 16'h6041, 32'h400, 32'h4400, 0);
		acc(1, 16'h6040, 32'h270, 32'h0, 0);
		idle(2);
		chk("relative_move", 32'h0, {31'h0, relative_move});
		acc(0, 16'h6041, 32'h400, 32'h4500, 0);
		acc(1, 16'h6040, 32'h4, 32'h0, 0);
		idle(3);
		chk("quick_stop", 32'h1, {31'h0, quick_stop});
		acc(0, 16'h6041, 32'h4000, 32'h4000, 0);
		// relative position mode ends when the target is reached, with no halt, quick stop or error
		acc(1, 16'h6040, 32'h0, 32'h0, 0);
		acc(1, 16'h6060, 32'h1, 32'h0, 0);
		acc(1, 16'h6040, 32'h40, 32'h0, 0);
		idle(2);
		chk("relative_move", 32'h1, {31'h0, relative_move});
		chk("mode_done", 32'h0, {31'h0, mode_done});
		pos_reached = 1;
		idle(2);
		chk("mode_done", 32'h1, {31'h0, mode_done});
		// error latch, fault reset and zero point
		error_seen = 1;
		zero_valid = 1;
		idle(2);
		acc(0, 16'h6041, 32'ha000, 32'ha000, 0);
		chk("status_word", 32'ha000, {16'h0, status_word & 16'ha000});
		error_seen = 0;
		acc(1, 16'h6040, 32'h80, 32'h0, 0);
		chk("fault_reset", 32'h1, {31'h0, fault_reset});
		idle(2);
		zero_valid = 0;
		acc(0, 16'h6041, 32'h0, 32'ha000, 0);
		acc(1, 16'h60f2, 32'h2, 32'h0, 0);
		chk("rel_from_actual", 32'h1, {31'h0, rel_from_actual});
		acc(0, 16'h60f2, 32'h2, F, 0);
		idle(3);
		chk("pending notes", 32'h0, notes.size());
		stop_test();
	end
endmodule // tb
